/* gpio8_port.sv */
`timescale 1ns/100ps
`include "gpio8_defines.svh"

module gpio8_port (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Serial host pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // General purpose pins
    input wire logic [7:0] io_i,
    output logic [7:0] io_o,
    output logic [7:0] io_oe_o,
    output logic [7:0] pullup_en_o,
    output logic [7:0] pulldown_en_o,
    // Open-drain interrupt line
    output logic irq_out_n_o,
    output logic irq_out_n_oe_o
);

    logic [7:0] rd_addr, wr_addr, wr_data, rd_data;
    logic wr_stb;

    logic [7:0] pin_level_value_q, pin_level_value_d;
    logic [7:0] pin_direction_q, pin_direction_d;
    logic [7:0] pullup_enable_q, pullup_enable_d;
    logic [7:0] pulldown_enable_q, pulldown_enable_d;
    logic [7:0] irq_block_mask_q, irq_block_mask_d;
    logic [7:0] edge_select_upper_q, edge_select_upper_d;
    logic [7:0] edge_select_lower_q, edge_select_lower_d;
    logic [1:0] upper_nibble_lookup_mode_q, upper_nibble_lookup_mode_d;
    logic [1:0] lower_nibble_lookup_mode_q, lower_nibble_lookup_mode_d;
    logic [7:0] two_input_truth_table_q, two_input_truth_table_d;
    logic [7:0] upper_trio_table_q, upper_trio_table_d;
    logic [7:0] lower_trio_table_q, lower_trio_table_d;

    logic [7:0] irq_pending_flags_q, irq_pending_flags_d;
    logic [7:0] edge_seen_flags_q, edge_seen_flags_d;
    logic [7:0] prev_q;
    logic primed_q;
    logic [7:0] hit, sense_chg, w1c;
    logic [15:0] sense_q, sense_d;

    logic [7:0] pin_out_d, pin_oe_d;
    logic irq_oe_d;

    // Serial register access
    ser_reg_port u_ser (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .rd_data_i(rd_data),
        .rd_addr_o(rd_addr),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .wr_stb_o(wr_stb)
    );

    // Configuration register writes
    always_comb begin
        pin_level_value_d = pin_level_value_q;
        pin_direction_d = pin_direction_q;
        pullup_enable_d = pullup_enable_q;
        pulldown_enable_d = pulldown_enable_q;
        irq_block_mask_d = irq_block_mask_q;
        edge_select_upper_d = edge_select_upper_q;
        edge_select_lower_d = edge_select_lower_q;
        upper_nibble_lookup_mode_d = upper_nibble_lookup_mode_q;
        lower_nibble_lookup_mode_d = lower_nibble_lookup_mode_q;
        two_input_truth_table_d = two_input_truth_table_q;
        upper_trio_table_d = upper_trio_table_q;
        lower_trio_table_d = lower_trio_table_q;
        if (wr_stb) begin
            case (wr_addr)
                `ADDR_DATA: pin_level_value_d = wr_data;
                `ADDR_DIR: pin_direction_d = wr_data;
                `ADDR_PULLUP: pullup_enable_d = wr_data;
                `ADDR_PULLDOWN: pulldown_enable_d = wr_data;
                `ADDR_MASK: irq_block_mask_d = wr_data;
                `ADDR_SENSE_HI: edge_select_upper_d = wr_data;
                `ADDR_SENSE_LO: edge_select_lower_d = wr_data;
                `ADDR_MODE: begin
                    // Reserved bits are dropped and read as zero
                    upper_nibble_lookup_mode_d = wr_data[`F_UPPER_MODE];
                    lower_nibble_lookup_mode_d = wr_data[`F_LOWER_MODE];
                end
                `ADDR_TABLE0: two_input_truth_table_d = wr_data;
                `ADDR_TABLE1: upper_trio_table_d = wr_data;
                `ADDR_TABLE2: lower_trio_table_d = wr_data;
                default: begin
                end
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pin_level_value_q <= `RST_ONES;
            pin_direction_q <= `RST_ONES;
            pullup_enable_q <= `RST_ZERO;
            pulldown_enable_q <= `RST_ZERO;
            irq_block_mask_q <= `RST_ONES;
            edge_select_upper_q <= `RST_ZERO;
            edge_select_lower_q <= `RST_ZERO;
            upper_nibble_lookup_mode_q <= `RST_MODE;
            lower_nibble_lookup_mode_q <= `RST_MODE;
            two_input_truth_table_q <= `RST_ZERO;
            upper_trio_table_q <= `RST_ZERO;
            lower_trio_table_q <= `RST_ZERO;
        end else begin
            pin_level_value_q <= pin_level_value_d;
            pin_direction_q <= pin_direction_d;
            pullup_enable_q <= pullup_enable_d;
            pulldown_enable_q <= pulldown_enable_d;
            irq_block_mask_q <= irq_block_mask_d;
            edge_select_upper_q <= edge_select_upper_d;
            edge_select_lower_q <= edge_select_lower_d;
            upper_nibble_lookup_mode_q <= upper_nibble_lookup_mode_d;
            lower_nibble_lookup_mode_q <= lower_nibble_lookup_mode_d;
            two_input_truth_table_q <= two_input_truth_table_d;
            upper_trio_table_q <= upper_trio_table_d;
            lower_trio_table_q <= lower_trio_table_d;
        end
    end

    // Sense fields by pin: pin i at bits 2i+1:2i
    assign sense_q = {edge_select_upper_q, edge_select_lower_q};
    assign sense_d = {edge_select_upper_d, edge_select_lower_d};

    // Per-pin edge match and sense change
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            logic [1:0] f;
            assign f = sense_q[2*gi +: 2];
            assign hit[gi] = primed_q & (
                (f[`SENSE_RISE_BIT] & io_i[gi] & ~prev_q[gi]) |
                (f[`SENSE_FALL_BIT] & ~io_i[gi] & prev_q[gi]));
            assign sense_chg[gi] =
                (sense_d[2*gi +: 2] != f);
        end
    endgenerate

    // Write-one-to-clear from either flag register
    assign w1c = (wr_stb && (wr_addr == `ADDR_IRQ_SRC ||
                 wr_addr == `ADDR_EVENTS)) ? wr_data : `RST_ZERO;

    // Flag update: a new edge wins over a clear in the same cycle
    always_comb begin
        edge_seen_flags_d = (edge_seen_flags_q & ~w1c & ~sense_chg)
                            | hit;
        irq_pending_flags_d = (irq_pending_flags_q & ~w1c & ~sense_chg)
                              | (hit & ~irq_block_mask_q);
        irq_oe_d = |irq_pending_flags_d;
    end

    // Flag and edge history registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            edge_seen_flags_q <= `RST_ZERO;
            irq_pending_flags_q <= `RST_ZERO;
            prev_q <= `RST_ZERO;
            primed_q <= 1'b0;
            irq_out_n_oe_o <= 1'b0;
            irq_out_n_o <= 1'b0;
        end else begin
            edge_seen_flags_q <= edge_seen_flags_d;
            irq_pending_flags_q <= irq_pending_flags_d;
            prev_q <= io_i;
            primed_q <= 1'b1;
            irq_out_n_oe_o <= irq_oe_d;
            irq_out_n_o <= 1'b0;
        end
    end

    // Pin drive: data latch, overridden by lookup logic
    always_comb begin
        pin_out_d = pin_level_value_q;
        pin_oe_d = ~pin_direction_q;
        case (upper_nibble_lookup_mode_q)
            `MODE_LUT2: begin
                pin_out_d[`PIN_LUT2_HI] = two_input_truth_table_q[
                    {`TBL_HI_HALF, io_i[`F_HI_PAIR]}];
                pin_oe_d[`PIN_LUT2_HI] = 1'b1;
            end
            `MODE_LUT3: begin
                pin_out_d[`PIN_LUT3_HI] =
                    upper_trio_table_q[io_i[`F_HI_TRIO]];
                pin_oe_d[`PIN_LUT3_HI] = 1'b1;
            end
            default: begin
            end
        endcase
        case (lower_nibble_lookup_mode_q)
            `MODE_LUT2: begin
                pin_out_d[`PIN_LUT2_LO] = two_input_truth_table_q[
                    {`TBL_LO_HALF, io_i[`F_LO_PAIR]}];
                pin_oe_d[`PIN_LUT2_LO] = 1'b1;
            end
            `MODE_LUT3: begin
                pin_out_d[`PIN_LUT3_LO] =
                    lower_trio_table_q[io_i[`F_LO_TRIO]];
                pin_oe_d[`PIN_LUT3_LO] = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // Registered pin outputs
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            io_o <= `RST_ONES;
            io_oe_o <= `RST_ZERO;
            pullup_en_o <= `RST_ZERO;
            pulldown_en_o <= `RST_ZERO;
        end else begin
            io_o <= pin_out_d;
            io_oe_o <= pin_oe_d;
            pullup_en_o <= pullup_enable_q;
            pulldown_en_o <= pulldown_enable_q;
        end
    end

    // Read mux; unmapped and reserved addresses read zero
    always_comb begin
        case (rd_addr)
            `ADDR_DATA: rd_data = io_i;
            `ADDR_DIR: rd_data = pin_direction_q;
            `ADDR_PULLUP: rd_data = pullup_enable_q;
            `ADDR_PULLDOWN: rd_data = pulldown_enable_q;
            `ADDR_MASK: rd_data = irq_block_mask_q;
            `ADDR_SENSE_HI: rd_data = edge_select_upper_q;
            `ADDR_SENSE_LO: rd_data = edge_select_lower_q;
            `ADDR_IRQ_SRC: rd_data = irq_pending_flags_q;
            `ADDR_EVENTS: rd_data = edge_seen_flags_q;
            `ADDR_MODE: rd_data = {2'h0, upper_nibble_lookup_mode_q,
                                   2'h0, lower_nibble_lookup_mode_q};
            `ADDR_TABLE0: rd_data = two_input_truth_table_q;
            `ADDR_TABLE1: rd_data = upper_trio_table_q;
            `ADDR_TABLE2: rd_data = lower_trio_table_q;
            default: rd_data = `RST_ZERO;
        endcase
    end

endmodule // gpio8_port

/* gpio8_defines.svh */
`ifndef GPIO8_DEFINES_SVH
`define GPIO8_DEFINES_SVH

// Register offsets
`define ADDR_DATA 8'h00
`define ADDR_DIR 8'h01
`define ADDR_PULLUP 8'h02
`define ADDR_PULLDOWN 8'h03
`define ADDR_MASK 8'h05
`define ADDR_SENSE_HI 8'h06
`define ADDR_SENSE_LO 8'h07
`define ADDR_IRQ_SRC 8'h08
`define ADDR_EVENTS 8'h09
`define ADDR_MODE 8'h10
`define ADDR_TABLE0 8'h11
`define ADDR_TABLE1 8'h12
`define ADDR_TABLE2 8'h13

// Reset values
`define RST_ONES 8'hFF
`define RST_ZERO 8'h00
`define RST_MODE 2'h0

// Edge sense coding: bit 0 rising, bit 1 falling
`define SENSE_RISE_BIT 0
`define SENSE_FALL_BIT 1

// Lookup mode field positions and codes
`define F_UPPER_MODE 5:4
`define F_LOWER_MODE 1:0
`define MODE_LUT2 2'h1
`define MODE_LUT3 2'h2

// Lookup pins and index fields
`define PIN_LUT2_HI 6
`define PIN_LUT3_HI 7
`define PIN_LUT2_LO 2
`define PIN_LUT3_LO 3
`define F_HI_PAIR 5:4
`define F_HI_TRIO 6:4
`define F_LO_PAIR 1:0
`define F_LO_TRIO 2:0
`define TBL_HI_HALF 1'h1
`define TBL_LO_HALF 1'h0

// Serial port: device address is arbitrary
`define DEV_ADDR 7'h20
`define BITS_PER_BYTE 4'h8
`define PTR_STEP 8'h01

`endif

/* gpio8_pkg.sv */
package gpio8_pkg;

    typedef enum logic [2:0] {
        SER_IDLE,
        SER_ADDR,
        SER_ACK_ADDR,
        SER_WRITE,
        SER_ACK_WR,
        SER_READ,
        SER_ACK_RD
    } ser_state_t;

endpackage

/* ser_reg_port.sv */
`timescale 1ns/100ps
`include "gpio8_defines.svh"

module ser_reg_port (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Two-wire serial pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Register side
    input wire logic [7:0] rd_data_i,
    output logic [7:0] rd_addr_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic wr_stb_o
);

    gpio8_pkg::ser_state_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] ptr_q, ptr_d;
    logic [7:0] wadr_q, wadr_d;
    logic [7:0] wdat_q, wdat_d;
    logic wstb_q, wstb_d;
    logic rw_q, rw_d;
    logic first_q, first_d;
    logic mack_q, mack_d;
    logic oe_q, oe_d;
    logic scl_q, sda_q;
    logic scl_rise, scl_fall, start_c, stop_c;

    // Bus condition detection against last samples
    assign scl_rise = scl_i & ~scl_q;
    assign scl_fall = ~scl_i & scl_q;
    assign start_c = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_c = scl_i & scl_q & ~sda_q & sda_i;

    // Byte engine with auto-incrementing register pointer
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        wadr_d = wadr_q;
        wdat_d = wdat_q;
        wstb_d = 1'b0;
        rw_d = rw_q;
        first_d = first_q;
        mack_d = mack_q;
        oe_d = oe_q;
        if (stop_c) begin
            st_d = gpio8_pkg::SER_IDLE;
            oe_d = 1'b0;
        end else if (start_c) begin
            st_d = gpio8_pkg::SER_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                gpio8_pkg::SER_IDLE: begin
                    oe_d = 1'b0;
                end
                gpio8_pkg::SER_ADDR, gpio8_pkg::SER_WRITE: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_i};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == `BITS_PER_BYTE) begin
                        oe_d = 1'b1; // Acknowledge
                        if (st_q == gpio8_pkg::SER_ADDR) begin
                            if (sh_q[7:1] == `DEV_ADDR) begin
                                rw_d = sh_q[0];
                                st_d = gpio8_pkg::SER_ACK_ADDR;
                            end else begin
                                oe_d = 1'b0;
                                st_d = gpio8_pkg::SER_IDLE;
                            end
                        end else begin
                            st_d = gpio8_pkg::SER_ACK_WR;
                            if (first_q) begin
                                ptr_d = sh_q;
                                first_d = 1'b0;
                            end else begin
                                wadr_d = ptr_q;
                                wdat_d = sh_q;
                                wstb_d = 1'b1;
                                ptr_d = ptr_q + `PTR_STEP;
                            end
                        end
                    end
                end
                gpio8_pkg::SER_ACK_ADDR: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (rw_q) begin
                            sh_d = rd_data_i;
                            oe_d = ~rd_data_i[7];
                            st_d = gpio8_pkg::SER_READ;
                        end else begin
                            oe_d = 1'b0;
                            first_d = 1'b1;
                            st_d = gpio8_pkg::SER_WRITE;
                        end
                    end
                end
                gpio8_pkg::SER_ACK_WR: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        cnt_d = 4'h0;
                        st_d = gpio8_pkg::SER_WRITE;
                    end
                end
                gpio8_pkg::SER_READ: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == `BITS_PER_BYTE) begin
                            oe_d = 1'b0;
                            ptr_d = ptr_q + `PTR_STEP;
                            st_d = gpio8_pkg::SER_ACK_RD;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = ~sh_q[6];
                        end
                    end
                end
                gpio8_pkg::SER_ACK_RD: begin
                    if (scl_rise) begin
                        mack_d = ~sda_i;
                    end else if (scl_fall) begin
                        if (mack_q) begin
                            sh_d = rd_data_i;
                            oe_d = ~rd_data_i[7];
                            cnt_d = 4'h0;
                            st_d = gpio8_pkg::SER_READ;
                        end else begin
                            st_d = gpio8_pkg::SER_IDLE;
                        end
                    end
                end
                default: begin
                    st_d = gpio8_pkg::SER_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= gpio8_pkg::SER_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            wadr_q <= 8'h00;
            wdat_q <= 8'h00;
            wstb_q <= 1'b0;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            mack_q <= 1'b0;
            oe_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sda_o <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            wadr_q <= wadr_d;
            wdat_q <= wdat_d;
            wstb_q <= wstb_d;
            rw_q <= rw_d;
            first_q <= first_d;
            mack_q <= mack_d;
            oe_q <= oe_d;
            scl_q <= scl_i;
            sda_q <= sda_i;
            sda_o <= 1'b0; // Open drain: only ever pulls low
        end
    end

    assign sda_oe_o = oe_q;
    assign rd_addr_o = ptr_q;
    assign wr_addr_o = wadr_q;
    assign wr_data_o = wdat_q;
    assign wr_stb_o = wstb_q;

endmodule // ser_reg_port

/* gpio8_chk_sva.sv */
`timescale 1ns/100ps

module gpio8_chk (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic scl_i,
    input wire logic [7:0] io_i,
    input wire logic [7:0] io_o,
    input wire logic [7:0] io_oe_o,
    input wire logic [7:0] pullup_en_o,
    input wire logic [7:0] pulldown_en_o,
    input wire logic irq_out_n_o,
    input wire logic irq_out_n_oe_o,
    input wire logic sda_oe_o
);
    logic scl_q;
    logic [3:0] gap_q, gap_d;
    // Clocks since the last SCL fall, saturating at 15
    always_comb begin
        gap_d = (gap_q == 4'hF) ? gap_q : gap_q + 4'h1;
        if (scl_q && !scl_i) begin
            gap_d = 4'h0;
        end
    end
    // Register the SCL sample and the gap count
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            scl_q <= 1'b1;
            gap_q <= 4'hF;
        end else begin
            scl_q <= scl_i;
            gap_q <= gap_d;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Outputs move only for a host write, a pin edge or a bus phase
    chk_reset_idle: assert property ($fell(rst_i) |->
        io_oe_o == 8'h00 && (pullup_en_o | pulldown_en_o) == 8'h00)
        else $error("outputs not idle after reset");
    chk_irq_value: assert property (irq_out_n_o == 1'b0)
        else $error("interrupt value not low");
    chk_irq_cause: assert property ($rose(irq_out_n_oe_o) |->
        $past(io_i) != $past(io_i, 2) || $past(io_i, 2) != $past(io_i, 3))
        else $error("interrupt without pin edge");
    chk_irq_clear: assert property ($fell(irq_out_n_oe_o) |->
        gap_q <= 4'h6) else $error("interrupt dropped without write");
    chk_pullup_write: assert property ($changed(pullup_en_o) |->
        gap_q <= 4'h6) else $error("pull-up moved without write");
    chk_pulldn_write: assert property ($changed(pulldown_en_o) |->
        gap_q <= 4'h6) else $error("pull-down moved without write");
    chk_dir_write: assert property ($changed(io_oe_o) |->
        gap_q <= 4'h7) else $error("drive enable moved without write");
    chk_sda_steady: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("SDA moved while SCL high");
    chk_lut_follow: assert property ($changed(io_o) |->
        gap_q <= 4'h7 || $past(io_i) != $past(io_i, 2)
        || $past(io_i, 2) != $past(io_i, 3)) else $error("output moved");
    cover property ($rose(irq_out_n_oe_o));
    cover property ($rose(sda_oe_o));
    cover property ($changed(io_o) && io_oe_o[2]);
endmodule // gpio8_chk

/* ser_host.sv */
`timescale 1ns/100ps
`include "gpio8_defines.svh"

module ser_host (
    // Clock and wire level
    input wire logic clk_sys_i,
    input wire logic sda_i,
    // Host drive, SDA pulled low while sda_low_o is high
    output logic scl_o,
    output logic sda_low_o
);
    // Idle bus: SCL high, SDA released
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // One step of four clocks, lines change just after an edge
    task automatic q(input logic c, input logic low);
        repeat (4) @(posedge clk_sys_i);
        scl_o <= c;
        sda_low_o <= low;
    endtask
    // One bit: SDA moves while SCL is low, sampled while high
    task automatic bt(input logic b, output logic r);
        q(1'b0, ~b);
        q(1'b1, ~b);
        q(1'b1, ~b);
        r = sda_i;
        q(1'b0, ~b);
    endtask
    // Byte plus acknowledge slot, am is sent in that slot
    task automatic xb(input logic [7:0] d, input logic am,
        output logic [7:0] r, output logic ok);
        logic a;
        for (int i = 7; i >= 0; i--)
            bt(d[i], r[i]);
        bt(am, a);
        ok = ~a;
    endtask
    // Start, or repeated start when rs is high
    task automatic go(input logic rs);
        if (rs) begin
            q(1'b0, 1'b0);
            q(1'b1, 1'b0);
        end
        q(1'b1, 1'b1);
        q(1'b0, 1'b1);
    endtask
    // Stop: SDA released while SCL is high
    task automatic stp();
        q(1'b0, 1'b1);
        q(1'b1, 1'b1);
        q(1'b1, 1'b0);
    endtask
    // Register write, ok when all three bytes were acknowledged
    task automatic wr(input logic [6:0] dev, input logic [7:0] p,
        input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic a, b, c;
        go(1'b0);
        xb({dev, 1'b0}, 1'b1, r, a);
        xb(p, 1'b1, r, b);
        xb(d, 1'b1, r, c);
        stp();
        ok = a & b & c;
    endtask
    // Register read: pointer, repeated start, one byte, then no-ack
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic [7:0] r;
        logic a;
        go(1'b0);
        xb({`DEV_ADDR, 1'b0}, 1'b1, r, a);
        xb(p, 1'b1, r, a);
        go(1'b1);
        xb({`DEV_ADDR, 1'b1}, 1'b1, r, a);
        xb(8'hFF, 1'b1, d, a);
        stp();
    endtask
endmodule // ser_host

/* tb_top.sv */
`timescale 1ns/100ps
`include "gpio8_defines.svh"

module tb_top;
    logic clk_sys_i;
    logic rst_i = 1'b1;
    logic scl, sda_low, sda_o, sda_oe_o, irq_v, irq_oe, ok;
    logic [7:0] ext = 8'h00;
    logic [7:0] io_o, io_oe_o, pu, pd, d;
    wire logic sda;
    wire logic [7:0] io_i;
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [7:0] lut_tbl = 8'h96;
    logic [7:0] ra [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
        8'h07, 8'h08, 8'h09, 8'h10};
    logic [7:0] rv [10] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00};
    // SDA has a pull-up; a pin shows its driven level or the outside one
    assign sda = ~(sda_low | (sda_oe_o & ~sda_o));
    assign io_i = (io_oe_o & io_o) | (~io_oe_o & ext);
    gpio8_port gpio8_port_i (.clk_sys_i, .rst_i, .scl_i(scl), .sda_i(sda),
        .sda_o, .sda_oe_o, .io_i, .io_o, .io_oe_o, .pullup_en_o(pu),
        .pulldown_en_o(pd), .irq_out_n_o(irq_v), .irq_out_n_oe_o(irq_oe));
    ser_host ser_host_i (.clk_sys_i, .sda_i(sda), .scl_o(scl),
        .sda_low_o(sda_low));
    // Clock
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        ser_host_i.wr(`DEV_ADDR, a, v, ok);
        chk("ack", 8'h01, {7'h0, ok});
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        ser_host_i.rd(a, d);
        chk("register", e, d);
    endtask
    task automatic pin(input logic [7:0] v);
        ext <= v;
        repeat (4) @(posedge clk_sys_i);
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        foreach (ra[i]) rreg(ra[i], rv[i]);
        wreg(`ADDR_PULLUP, 8'hA5);
        wreg(`ADDR_PULLDOWN, 8'h5A);
        chk("pullup", 8'hA5, pu);
        chk("pulldown", 8'h5A, pd);
        pin(8'h09);
        wreg(`ADDR_DIR, 8'h0F);
        wreg(`ADDR_DATA, 8'h3C);
        chk("dir", 8'hF0, io_oe_o);
        rreg(`ADDR_DATA, 8'h39);
        wreg(`ADDR_DIR, 8'hFF);
        pin(8'h00);
        for (int c = 0; c < 4; c++) begin
            wreg(`ADDR_SENSE_LO, 8'(c));
            pin(8'h01);
            rreg(`ADDR_EVENTS, {7'h0, c[0]});
            pin(8'h00);
            rreg(`ADDR_EVENTS, {7'h0, c[0] | c[1]});
            wreg(`ADDR_EVENTS, 8'h01);
            chk("masked", 8'h00, {7'h0, irq_oe});
        end
        wreg(`ADDR_MASK, 8'h7F);
        wreg(`ADDR_SENSE_HI, 8'h40);
        pin(8'h80);
        rreg(`ADDR_IRQ_SRC, 8'h80);
        wreg(`ADDR_IRQ_SRC, 8'h00);
        chk("irq", 8'h01, {7'h0, irq_oe});
        wreg(`ADDR_IRQ_SRC, 8'h80);
        rreg(`ADDR_EVENTS, 8'h00);
        chk("irq", 8'h00, {7'h0, irq_oe});
        pin(8'h00);
        pin(8'h80);
        wreg(`ADDR_EVENTS, 8'h80);
        rreg(`ADDR_IRQ_SRC, 8'h00);
        pin(8'h00);
        pin(8'h80);
        wreg(`ADDR_SENSE_HI, 8'hC0);
        rreg(`ADDR_IRQ_SRC, 8'h00);
        wreg(`ADDR_TABLE0, lut_tbl);
        wreg(`ADDR_MODE, 8'h11);
        for (int i = 0; i < 4; i++) begin
            pin({2'h2, 2'(i), 2'h0, 2'(i)});
            chk("lut", {6'h0, lut_tbl[4 + i], lut_tbl[i]},
                {6'h0, io_o[6], io_o[2]});
        end
        // Three-input lookup on both nibbles, then the spare code
        wreg(`ADDR_TABLE1, lut_tbl);
        wreg(`ADDR_TABLE2, ~lut_tbl);
        wreg(`ADDR_MODE, 8'h22);
        for (int i = 0; i < 8; i++) begin
            pin({1'b0, 3'(i), 1'b0, 3'(i)});
            chk("lut3", {6'h0, lut_tbl[i], ~lut_tbl[i]},
                {6'h0, io_o[7], io_o[3]});
        end
        wreg(`ADDR_MODE, 8'h33);
        chk("mode3", 8'h00, io_oe_o);
        wreg(`ADDR_MODE, 8'h00);
        chk("plain", 8'h00, io_oe_o);
        ser_host_i.wr(7'h21, `ADDR_PULLUP, 8'hFF, ok);
        chk("nack", 8'h00, {7'h0, ok});
        chk("pullup", 8'hA5, pu);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        chk("pulls", 8'h00, pu | pd);
        chk("data", 8'hFF, io_o);
        chk("irq", 8'h00, {5'h0, sda_o, irq_v, irq_oe});
        rreg(`ADDR_MASK, 8'hFF);
        tally_and_finish();
    end
endmodule // tb_top

bind gpio8_port gpio8_chk gpio8_chk_i (.clk_sys_i, .rst_i, .scl_i, .io_i,
    .io_o, .io_oe_o, .pullup_en_o, .pulldown_en_o, .irq_out_n_o,
    .irq_out_n_oe_o, .sda_oe_o);
